/* mcu_exec_pkg.sv */
// Package: opcodes, request carrier, register map and flag layout for the execute block
package mcu_exec_pkg;
   // ----------------------------------------
   // Widths
   // ----------------------------------------
   localparam int DADDR_W = 11;
   localparam int PADDR_W = 14;
   localparam int PAGE_W  = PADDR_W - 8;

   // ----------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] REG_WORK   = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_LOOKHI = 8'h08;
   localparam logic [7:0] REG_TBLPTR = 8'h0c;

   // ----------------------------------------
   // Status bit positions and reset values
   // ----------------------------------------
   localparam int ST_C  = 0;
   localparam int ST_NIB = 1;
   localparam int ST_Z   = 2;
   localparam int ST_SR  = 3;
   localparam int ST_PD  = 4;
   localparam int ST_TMO = 5;
   localparam logic [7:0] RST_BYTE = 8'h00;

   typedef enum logic [4:0] {
      OP_NOP   = 5'h00,
      OP_ADD_M = 5'h01,
      OP_ADC_M = 5'h02,
      OP_ADD_I = 5'h03,
      OP_ADD_TO_M = 5'h04,
      OP_ADC_TO_M = 5'h05,
      OP_AND_M = 5'h06,
      OP_AND_I = 5'h07,
      OP_AND_TO_M = 5'h08,
      OP_SWAP  = 5'h09,
      OP_SWAP_W = 5'h0a,
      OP_HALT  = 5'h0b,
      OP_CLRWDT = 5'h0c,
      OP_PRE1  = 5'h0d,
      OP_PRE2  = 5'h0e,
      OP_RDC   = 5'h0f,
      OP_RDL   = 5'h10,
      OP_SKIP  = 5'h11
   } op_e;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b01,
      ST_SECOND = 2'b10
   } state_e;

   typedef enum logic [1:0] {
      PRE_NONE = 2'h0,
      PRE_ONE  = 2'h1,
      PRE_TWO  = 2'h2
   } pre_e;

   typedef struct packed {
      op_e                op;
      logic [7:0]         mdata;
      logic [7:0]         imm;
      logic [DADDR_W-1:0] addr;
      logic [PAGE_W-1:0]  page;
      logic               skip;
      logic               prog_counter_low_wr;
   } exe_req_s;
endpackage

/* mcu_alu_table_misc_exec.sv */
// Execute unit for add, AND, table read and miscellaneous instructions
// Function
// - table read current page, two cycles
// - table read last page, two cycles, no flags
// - nibble swap to memory or working register
// - halt enters power down, updates flags
// - skip takes two cycles only when skipping
// - writes to prog_counter_low take two cycles
// - preclear pair clears flags only when consecutive
// - add with carry into working register
// - add memory byte into working register
// - add immediate into working register
// - add working register into memory byte
// - AND memory into working register, zero only
// - AND immediate into working register, zero only
// - watchdog clear resets counter and flags
//
// Design decisions made here: the Wishbone register port and the register addresses.
`timescale 1ns/100ps
module mcu_alu_table_misc_exec (
   // Clock and reset
   input  wire logic                            sys_clk_i,
   input  wire logic                            srst_i,
   // Wishbone slave
   input  wire logic                            wb_cyc_i,
   input  wire logic                            wb_stb_i,
   input  wire logic                            wb_we_i,
   input  wire logic [3:0]                      wb_sel_i,
   input  wire logic [7:0]                      wb_adr_i,
   input  wire logic [31:0]                     wb_dat_i,
   output logic      [31:0]                     wb_dat_o,
   output logic                                 wb_ack_o,
   // Instruction request from decode
   input  wire logic                            exe_valid_i,
   input  wire mcu_exec_pkg::exe_req_s          exe_req_i,
   output logic                                 exe_ready_o,
   output logic                                 exe_done_o,
   // Data memory write port
   output logic                                 mem_we_o,
   output logic [mcu_exec_pkg::DADDR_W-1:0]     mem_addr_o,
   output logic [7:0]                           mem_wdata_o,
   // Program memory read port, combinational read
   output logic                                 prog_rd_o,
   output logic [mcu_exec_pkg::PADDR_W-1:0]     prog_addr_o,
   input  wire logic [15:0]                     prog_data_i,
   // Watchdog and power control
   input  wire logic                            wdt_timeout_i,
   input  wire logic                            wake_i,
   output logic                                 wdt_clear_o,
   output logic                                 powerdown_o
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   mcu_exec_pkg::state_e   state_reg;
   mcu_exec_pkg::pre_e     pre_reg;
   mcu_exec_pkg::exe_req_s req_reg;
   logic [7:0]  working_register_reg;
   logic [7:0]  lookup_high_byte_reg;
   logic [7:0]  tbl_ptr_reg;
   logic        carry_reg;
   logic        nibble_carry_flag_reg;
   logic        zero_reg;
   logic        signed_range_flag_reg;
   logic        watchdog_timeout_flag_reg;
   logic        powerdown_flag_reg;
   logic        powerdown_reg;
   logic        done_reg;
   logic        wdt_clear_reg;
   logic        mem_we_reg;
   logic [mcu_exec_pkg::DADDR_W-1:0] mem_addr_reg;
   logic [7:0]  mem_wdata_reg;
   logic        prog_rd_reg;
   logic [mcu_exec_pkg::PADDR_W-1:0] prog_addr_reg;
   logic        ack_reg;
   logic [31:0] dat_reg;

   mcu_exec_pkg::op_e op;
   logic        accept;
   logic        two_cycle;
   logic        is_add;
   logic        is_and;
   logic        to_work;
   logic        to_mem;
   logic        table_op;
   logic        wdt_fire;
   logic [7:0]  opnd_b;
   logic        cin;
   logic [8:0]  sum9;
   logic [4:0]  half5;
   logic [7:0]  andv;
   logic [7:0]  swapv;
   logic [7:0]  result;
   logic        wb_wr;
   logic [7:0]  status_v;

   // ----------------------------------------
   // Decode and datapath
   // ----------------------------------------
   assign op          = exe_req_i.op;
   assign exe_ready_o = (state_reg == mcu_exec_pkg::ST_IDLE) && !powerdown_reg;
   assign accept      = exe_valid_i && exe_ready_o;
   assign table_op    = (op == mcu_exec_pkg::OP_RDC) || (op == mcu_exec_pkg::OP_RDL);
   assign two_cycle   = table_op
                      || ((op == mcu_exec_pkg::OP_SKIP) && exe_req_i.skip)
                      || exe_req_i.prog_counter_low_wr;
   assign is_add = (op == mcu_exec_pkg::OP_ADD_M) || (op == mcu_exec_pkg::OP_ADC_M)
                || (op == mcu_exec_pkg::OP_ADD_I) || (op == mcu_exec_pkg::OP_ADD_TO_M)
                || (op == mcu_exec_pkg::OP_ADC_TO_M);
   assign is_and = (op == mcu_exec_pkg::OP_AND_M) || (op == mcu_exec_pkg::OP_AND_I)
                || (op == mcu_exec_pkg::OP_AND_TO_M);
   assign to_mem = (op == mcu_exec_pkg::OP_ADD_TO_M) || (op == mcu_exec_pkg::OP_ADC_TO_M)
                || (op == mcu_exec_pkg::OP_AND_TO_M) || (op == mcu_exec_pkg::OP_SWAP);
   assign to_work = (is_add || is_and || (op == mcu_exec_pkg::OP_SWAP_W)) && !to_mem;

   assign opnd_b = ((op == mcu_exec_pkg::OP_ADD_I) || (op == mcu_exec_pkg::OP_AND_I))
                 ? exe_req_i.imm : exe_req_i.mdata;
   assign cin    = ((op == mcu_exec_pkg::OP_ADC_M) || (op == mcu_exec_pkg::OP_ADC_TO_M))
                 && carry_reg;
   assign sum9   = {1'b0, working_register_reg} + {1'b0, opnd_b} + {8'h00, cin};
   assign half5  = {1'b0, working_register_reg[3:0]} + {1'b0, opnd_b[3:0]} + {4'h0, cin};
   assign andv   = working_register_reg & opnd_b;
   assign swapv  = {exe_req_i.mdata[3:0], exe_req_i.mdata[7:4]};
   assign result = is_add ? sum9[7:0] : (is_and ? andv : swapv);

   // Alternate preclears only count when back to back
   assign wdt_fire = accept && ((op == mcu_exec_pkg::OP_CLRWDT)
                  || ((op == mcu_exec_pkg::OP_PRE1) && (pre_reg == mcu_exec_pkg::PRE_TWO))
                  || ((op == mcu_exec_pkg::OP_PRE2) && (pre_reg == mcu_exec_pkg::PRE_ONE)));

   // ----------------------------------------
   // Sequencing
   // ----------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         state_reg <= mcu_exec_pkg::ST_IDLE;
      end else begin
         case (state_reg)
            mcu_exec_pkg::ST_IDLE: begin
               if (accept && two_cycle) begin
                  state_reg <= mcu_exec_pkg::ST_SECOND;
               end
            end
            mcu_exec_pkg::ST_SECOND: state_reg <= mcu_exec_pkg::ST_IDLE;
            default: state_reg <= mcu_exec_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         req_reg  <= '0;
         done_reg <= 1'b0;
      end else begin
         if (accept) begin
            req_reg <= exe_req_i;
         end
         done_reg <= (accept && !two_cycle) || (state_reg == mcu_exec_pkg::ST_SECOND);
      end
   end

   // ----------------------------------------
   // Working register
   // ----------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         working_register_reg <= mcu_exec_pkg::RST_BYTE;
      end else if (accept && to_work) begin
         working_register_reg <= result;
      end else if (wb_wr && (wb_adr_i == mcu_exec_pkg::REG_WORK)) begin
         working_register_reg <= wb_dat_i[7:0];
      end
   end

   // ----------------------------------------
   // Arithmetic flags; an executing instruction beats a software write
   // ----------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         carry_reg             <= 1'b0;
         nibble_carry_flag_reg <= 1'b0;
         zero_reg              <= 1'b0;
         signed_range_flag_reg <= 1'b0;
      end else if (accept && is_add) begin
         carry_reg             <= sum9[8];
         nibble_carry_flag_reg <= half5[4];
         zero_reg              <= (sum9[7:0] == 8'h00);
         signed_range_flag_reg <= (working_register_reg[7] == opnd_b[7])
                               && (sum9[7] != working_register_reg[7]);
      end else if (accept && is_and) begin
         zero_reg <= (andv == 8'h00);
      end else if (wb_wr && (wb_adr_i == mcu_exec_pkg::REG_STATUS)) begin
         carry_reg             <= wb_dat_i[mcu_exec_pkg::ST_C];
         nibble_carry_flag_reg <= wb_dat_i[mcu_exec_pkg::ST_NIB];
         zero_reg              <= wb_dat_i[mcu_exec_pkg::ST_Z];
         signed_range_flag_reg <= wb_dat_i[mcu_exec_pkg::ST_SR];
      end
   end

   // ----------------------------------------
   // Watchdog flags and power down
   // ----------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         pre_reg <= mcu_exec_pkg::PRE_NONE;
      end else if (accept) begin
         // A completed pair starts over, so a lone third preclear does nothing
         if ((op == mcu_exec_pkg::OP_PRE1) && !wdt_fire) begin
            pre_reg <= mcu_exec_pkg::PRE_ONE;
         end else if ((op == mcu_exec_pkg::OP_PRE2) && !wdt_fire) begin
            pre_reg <= mcu_exec_pkg::PRE_TWO;
         end else begin
            pre_reg <= mcu_exec_pkg::PRE_NONE;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         watchdog_timeout_flag_reg <= 1'b0;
         powerdown_flag_reg        <= 1'b0;
         wdt_clear_reg             <= 1'b0;
      end else begin
         wdt_clear_reg <= wdt_fire;
         if (wdt_timeout_i) begin
            watchdog_timeout_flag_reg <= 1'b1;
         end else if (wdt_fire || (accept && (op == mcu_exec_pkg::OP_HALT))) begin
            watchdog_timeout_flag_reg <= 1'b0;
         end
         if (accept && (op == mcu_exec_pkg::OP_HALT)) begin
            powerdown_flag_reg <= 1'b1;
         end else if (wdt_fire) begin
            powerdown_flag_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         powerdown_reg <= 1'b0;
      end else if (accept && (op == mcu_exec_pkg::OP_HALT)) begin
         powerdown_reg <= 1'b1;
      end else if (wake_i) begin
         powerdown_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // Data and program memory ports
   // ----------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         mem_we_reg    <= 1'b0;
         mem_addr_reg  <= '0;
         mem_wdata_reg <= mcu_exec_pkg::RST_BYTE;
      end else if (accept && to_mem) begin
         mem_we_reg    <= 1'b1;
         mem_addr_reg  <= exe_req_i.addr;
         mem_wdata_reg <= result;
      end else if ((state_reg == mcu_exec_pkg::ST_SECOND)
                   && ((req_reg.op == mcu_exec_pkg::OP_RDC)
                   || (req_reg.op == mcu_exec_pkg::OP_RDL))) begin
         mem_we_reg    <= 1'b1;
         mem_addr_reg  <= req_reg.addr;
         mem_wdata_reg <= prog_data_i[7:0];
      end else begin
         mem_we_reg <= 1'b0;
      end
   end

   // Program memory is read combinationally in the second cycle
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         prog_rd_reg          <= 1'b0;
         prog_addr_reg        <= '0;
         lookup_high_byte_reg <= mcu_exec_pkg::RST_BYTE;
      end else begin
         prog_rd_reg <= accept && table_op;
         if (accept && (op == mcu_exec_pkg::OP_RDC)) begin
            prog_addr_reg <= {exe_req_i.page, tbl_ptr_reg};
         end else if (accept && (op == mcu_exec_pkg::OP_RDL)) begin
            prog_addr_reg <= {{mcu_exec_pkg::PAGE_W{1'b1}}, tbl_ptr_reg};
         end
         if (prog_rd_reg) begin
            lookup_high_byte_reg <= prog_data_i[15:8];
         end
      end
   end

   // ----------------------------------------
   // Wishbone slave, one wait state
   // ----------------------------------------
   assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg && wb_sel_i[0];
   assign status_v = {2'b00, watchdog_timeout_flag_reg, powerdown_flag_reg,
                      signed_range_flag_reg, zero_reg, nibble_carry_flag_reg, carry_reg};

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         tbl_ptr_reg <= mcu_exec_pkg::RST_BYTE;
      end else if (wb_wr && (wb_adr_i == mcu_exec_pkg::REG_TBLPTR)) begin
         tbl_ptr_reg <= wb_dat_i[7:0];
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         ack_reg <= 1'b0;
         dat_reg <= '0;
      end else begin
         ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
         case (wb_adr_i)
            mcu_exec_pkg::REG_WORK:   dat_reg <= {24'h000000, working_register_reg};
            mcu_exec_pkg::REG_STATUS: dat_reg <= {24'h000000, status_v};
            mcu_exec_pkg::REG_LOOKHI: dat_reg <= {24'h000000, lookup_high_byte_reg};
            mcu_exec_pkg::REG_TBLPTR: dat_reg <= {24'h000000, tbl_ptr_reg};
            default:                  dat_reg <= 32'h00000000;
         endcase
      end
   end

   assign wb_ack_o    = ack_reg;
   assign wb_dat_o    = dat_reg;
   assign exe_done_o  = done_reg;
   assign mem_we_o    = mem_we_reg;
   assign mem_addr_o  = mem_addr_reg;
   assign mem_wdata_o = mem_wdata_reg;
   assign prog_rd_o   = prog_rd_reg;
   assign prog_addr_o = prog_addr_reg;
   assign wdt_clear_o = wdt_clear_reg;
   assign powerdown_o = powerdown_reg;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   property p_tbl_two;
      @(posedge sys_clk_i) disable iff (srst_i)
      (accept && (op == mcu_exec_pkg::OP_RDC)) |=> !exe_ready_o && prog_rd_o ##1 exe_done_o
         && mem_we_o;
   endproperty
   a_tbl_two: assert property (p_tbl_two) else $error("table read not two cycles");

   property p_tbl_last;
      @(posedge sys_clk_i) disable iff (srst_i)
      (accept && (op == mcu_exec_pkg::OP_RDL)) |=> (&prog_addr_o[mcu_exec_pkg::PADDR_W-1:8])
         && $stable(zero_reg) && $stable(carry_reg);
   endproperty
   a_tbl_last: assert property (p_tbl_last) else $error("last page read wrong");

   property p_swap;
      @(posedge sys_clk_i) disable iff (srst_i)
      (accept && (op == mcu_exec_pkg::OP_SWAP)) |=> mem_we_o && (mem_wdata_o == $past(swapv))
         && $stable(zero_reg);
   endproperty
   a_swap: assert property (p_swap) else $error("swap result wrong");

   property p_halt;
      @(posedge sys_clk_i) disable iff (srst_i)
      (accept && (op == mcu_exec_pkg::OP_HALT) && !wdt_timeout_i) |=> powerdown_o
         && powerdown_flag_reg && !watchdog_timeout_flag_reg && !exe_ready_o;
   endproperty
   a_halt: assert property (p_halt) else $error("halt did not power down");

   property p_noskip;
      @(posedge sys_clk_i) disable iff (srst_i)
      (accept && (op == mcu_exec_pkg::OP_SKIP) && !exe_req_i.skip
         && !exe_req_i.prog_counter_low_wr) |=> exe_done_o && exe_ready_o;
   endproperty
   a_noskip: assert property (p_noskip) else $error("unskipped skip not one cycle");

   property p_prog_counter_low;
      @(posedge sys_clk_i) disable iff (srst_i)
      (accept && exe_req_i.prog_counter_low_wr) |=> !exe_done_o && !exe_ready_o
         ##1 exe_done_o;
   endproperty
   a_prog_counter_low: assert property (p_prog_counter_low)
      else $error("prog_counter_low write not two cycles");

   property p_pre_lone;
      @(posedge sys_clk_i) disable iff (srst_i)
      (accept && (op == mcu_exec_pkg::OP_PRE1) && (pre_reg != mcu_exec_pkg::PRE_TWO)
         && !wdt_timeout_i) |=> $stable(watchdog_timeout_flag_reg)
         && $stable(powerdown_flag_reg) && !wdt_clear_o;
   endproperty
   a_pre_lone: assert property (p_pre_lone) else $error("lone preclear changed flags");

   property p_adc;
      @(posedge sys_clk_i) disable iff (srst_i)
      (accept && (op == mcu_exec_pkg::OP_ADC_M)) |=> (working_register_reg == $past(sum9[7:0]))
         && (carry_reg == $past(sum9[8])) && (zero_reg == ($past(sum9[7:0]) == 8'h00));
   endproperty
   a_adc: assert property (p_adc) else $error("add with carry wrong");

   property p_and;
      @(posedge sys_clk_i) disable iff (srst_i)
      (accept && (op == mcu_exec_pkg::OP_AND_M)) |=> (working_register_reg == $past(andv))
         && (zero_reg == ($past(andv) == 8'h00)) && $stable(carry_reg);
   endproperty
   a_and: assert property (p_and) else $error("and result or flags wrong");

   property p_clrwdt;
      @(posedge sys_clk_i) disable iff (srst_i)
      (accept && (op == mcu_exec_pkg::OP_CLRWDT) && !wdt_timeout_i) |=> wdt_clear_o
         && !watchdog_timeout_flag_reg && !powerdown_flag_reg;
   endproperty
   a_clrwdt: assert property (p_clrwdt) else $error("watchdog clear failed");

endmodule // mcu_alu_table_misc_exec

/* tb_mcu_alu_table_misc_exec.sv */
// Self-checking testbench for the add, AND, table read and misc execute unit
`timescale 1ns/100ps
module tb_mcu_alu_table_misc_exec;
   // ----------------------------------------
   // Signals and design
   // ----------------------------------------
   logic                     clk, rst, cyc, stb, we, ack, valid, ready, done;
   logic                     mwe, prd, wto, wake, wclr, pdn, mseen, wc;
   logic [3:0]               sel;
   logic [7:0]               adr, mdat, mwd;
   logic [31:0]              dwr, drd, rv;
   logic [10:0]              maddr;
   logic [13:0]              paddr, pa;
   logic [15:0]              pdata;
   mcu_exec_pkg::exe_req_s   req;
   int                       fails, check_count;
   int                       cycles = 0;

   // Program word differs per page and offset, so a wrong address shows in the data
   assign pdata = {paddr[7:0], paddr[13:6]};

   mcu_alu_table_misc_exec mcu_alu_table_misc_exec_i (
      .sys_clk_i(clk), .srst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(dwr), .wb_dat_o(drd), .wb_ack_o(ack),
      .exe_valid_i(valid), .exe_req_i(req), .exe_ready_o(ready), .exe_done_o(done),
      .mem_we_o(mwe), .mem_addr_o(maddr), .mem_wdata_o(mdat), .prog_rd_o(prd),
      .prog_addr_o(paddr), .prog_data_i(pdata), .wdt_timeout_i(wto), .wake_i(wake),
      .wdt_clear_o(wclr), .powerdown_o(pdn));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Wait has no own bound: the cycle ceiling below ends a hung bus
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dwr <= {24'h0, d};
      do @(posedge clk); while (ack !== 1'b1);
      rv = drd;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
      wb(1'b0, a, 8'h00);
      chk(nm, {24'h0, e}, rv);
   endtask

   task automatic mchk(input logic [7:0] e);
      chk("mem_write", {23'h0, 1'b1, e}, {23'h0, mseen, mwd});
   endtask

   task automatic pulse(input logic [1:0] p);
      @(posedge clk);
      {wake, wto} <= p;
      @(posedge clk);
      {wake, wto} <= 2'b00;
   endtask

   // Issues one instruction and watches every cycle up to its done pulse
   task automatic exe(input mcu_exec_pkg::op_e op, input logic [7:0] m = 8'h00,
                      input logic [7:0] im = 8'h00, input logic [5:0] pg = 6'h05,
                      input logic sk = 1'b0, input logic pw = 1'b0, input int lat = 1);
      int n;
      @(posedge clk);
      valid <= 1'b1;
      req <= '{op, m, im, 11'h123, pg, sk, pw};
      @(posedge clk);
      valid <= 1'b0;
      mseen = 1'b0;
      wc = 1'b0;
      pa = '0;
      for (n = 1; n < 8; n++) begin
         #1;
         if (mwe === 1'b1) begin
            mseen = 1'b1;
            mwd = mdat;
            chk("mem_addr", 32'h123, {21'h0, maddr});
         end
         if (prd === 1'b1)
            pa = paddr;
         wc = wc | wclr;
         if (done === 1'b1)
            break;
         @(posedge clk);
      end
      chk("latency", lat, n);
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         fails++;
         give_verdict();
      end
   end

   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      // Reset starts asserted; every other input starts idle
      rst = 1'b1;
      {cyc, stb, we, valid, wto, wake} = 6'h00;
      sel = 4'h1;
      adr = 8'h00;
      dwr = 32'h0;
      req = '0;
      fails = 0;
      check_count = 0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rchk("status", mcu_exec_pkg::REG_STATUS, 8'h00);
      wb(1'b1, mcu_exec_pkg::REG_WORK, 8'h7f);
      exe(mcu_exec_pkg::OP_ADD_I, 8'h00, 8'h01);
      rchk("work", mcu_exec_pkg::REG_WORK, 8'h80);
      rchk("status", mcu_exec_pkg::REG_STATUS, 8'h0a);
      exe(mcu_exec_pkg::OP_ADD_M, 8'h80);
      rchk("status", mcu_exec_pkg::REG_STATUS, 8'h0d);
      exe(mcu_exec_pkg::OP_ADC_M, 8'h0f);
      rchk("work", mcu_exec_pkg::REG_WORK, 8'h10);
      rchk("status", mcu_exec_pkg::REG_STATUS, 8'h02);
      exe(mcu_exec_pkg::OP_ADD_TO_M, 8'hf0);
      mchk(8'h00);
      rchk("status", mcu_exec_pkg::REG_STATUS, 8'h05);
      exe(mcu_exec_pkg::OP_ADC_TO_M, 8'h01);
      mchk(8'h12);
      rchk("status", mcu_exec_pkg::REG_STATUS, 8'h00);
      $display("add test done");
      wb(1'b1, mcu_exec_pkg::REG_STATUS, 8'h0b);
      exe(mcu_exec_pkg::OP_AND_M, 8'h0f);
      rchk("status", mcu_exec_pkg::REG_STATUS, 8'h0f);
      wb(1'b1, mcu_exec_pkg::REG_WORK, 8'hf3);
      exe(mcu_exec_pkg::OP_AND_I, 8'h00, 8'h3c);
      rchk("work", mcu_exec_pkg::REG_WORK, 8'h30);
      rchk("status", mcu_exec_pkg::REG_STATUS, 8'h0b);
      exe(mcu_exec_pkg::OP_AND_TO_M, 8'h20);
      mchk(8'h20);
      exe(mcu_exec_pkg::OP_SWAP, 8'ha5);
      mchk(8'h5a);
      exe(mcu_exec_pkg::OP_SWAP_W, 8'hc3);
      rchk("work", mcu_exec_pkg::REG_WORK, 8'h3c);
      rchk("status", mcu_exec_pkg::REG_STATUS, 8'h0b);
      $display("logic test done");
      wb(1'b1, mcu_exec_pkg::REG_TBLPTR, 8'h34);
      exe(mcu_exec_pkg::OP_RDC, 8'h00, 8'h00, 6'h05, 1'b0, 1'b0, 2);
      chk("prog_addr", 32'h0534, {18'h0, pa});
      mchk(8'h14);
      rchk("lookup_high", mcu_exec_pkg::REG_LOOKHI, 8'h34);
      exe(mcu_exec_pkg::OP_RDL, 8'h00, 8'h00, 6'h05, 1'b0, 1'b0, 2);
      chk("prog_addr", 32'h3f34, {18'h0, pa});
      mchk(8'hfc);
      rchk("status", mcu_exec_pkg::REG_STATUS, 8'h0b);
      wb(1'b1, mcu_exec_pkg::REG_LOOKHI, 8'hff);
      rchk("lookup_high", mcu_exec_pkg::REG_LOOKHI, 8'h34);
      rchk("unmapped", 8'h10, 8'h00);
      exe(mcu_exec_pkg::OP_SKIP, 8'h00, 8'h00, 6'h05, 1'b1, 1'b0, 2);
      exe(mcu_exec_pkg::OP_SKIP, 8'h00, 8'h00, 6'h05, 1'b0, 1'b0, 1);
      exe(mcu_exec_pkg::OP_NOP, 8'h00, 8'h00, 6'h05, 1'b0, 1'b1, 2);
      $display("table and timing test done");
      pulse(2'b01);
      rchk("status", mcu_exec_pkg::REG_STATUS, 8'h2b);
      exe(mcu_exec_pkg::OP_HALT);
      rchk("status", mcu_exec_pkg::REG_STATUS, 8'h1b);
      chk("powerdown", 32'h1, {31'h0, pdn});
      chk("ready", 32'h0, {31'h0, ready});
      pulse(2'b10);
      #1;
      chk("powerdown", 32'h0, {31'h0, pdn});
      exe(mcu_exec_pkg::OP_PRE1);
      exe(mcu_exec_pkg::OP_NOP);
      exe(mcu_exec_pkg::OP_PRE2);
      chk("wdt_clear", 32'h0, {31'h0, wc});
      rchk("status", mcu_exec_pkg::REG_STATUS, 8'h1b);
      exe(mcu_exec_pkg::OP_PRE1);
      chk("wdt_clear", 32'h1, {31'h0, wc});
      rchk("status", mcu_exec_pkg::REG_STATUS, 8'h0b);
      pulse(2'b01);
      exe(mcu_exec_pkg::OP_CLRWDT);
      chk("wdt_clear", 32'h1, {31'h0, wc});
      rchk("status", mcu_exec_pkg::REG_STATUS, 8'h0b);
      $display("watchdog test done");
      give_verdict();
   end
endmodule // tb_mcu_alu_table_misc_exec
